/* hdl/scd_top.sv */
`timescale 1ns/10ps
`default_nettype none
module scd_top #(
    parameter int DQ_W = 64,
    parameter int MASK_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clock_enable_input,
    input wire scd_pkg::scd_cmd_pins_type cmd_pins,
    input wire logic [scd_pkg::ROW_W-1:0] address,
    input wire logic bank_select,
    input wire logic bank_select_high,
    input wire logic [MASK_W-1:0] byte_mask,
    input wire logic [DQ_W-1:0] dq_in,
    output logic [DQ_W-1:0] dq_out,
    output logic [MASK_W-1:0] dq_oe,
    output scd_pkg::scd_arr_type arr_wr,
    output logic [DQ_W-1:0] arr_wr_data,
    output logic [MASK_W-1:0] arr_wr_be,
    output scd_pkg::scd_arr_type arr_rd,
    input wire logic [DQ_W-1:0] arr_rd_data,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [scd_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [scd_pkg::AXI_AW-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    import scd_pkg::*;

    localparam int NBANK = 2 ** BANK_W;

    initial begin
        if (DQ_W != MASK_W * 8 || MASK_W < 1) begin
            $error("scd_top: DQ_W must be eight bits per mask bit");
        end
    end

    scd_cmd_type cmd;
    scd_pwr_type pwr_ff, nxt_pwr;
    logic [MODE_W-1:0] mode_ff, nxt_mode;
    logic [NBANK-1:0] open_ff, nxt_open;
    logic [ROW_W-1:0] row_ff [NBANK], nxt_row [NBANK];
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [ROW_W-1:0] refresh_ff, nxt_refresh;
    logic bwrite_ff, nxt_bwrite, bap_ff, nxt_bap;
    logic [BANK_W-1:0] bbank_ff, nxt_bbank;
    scd_arr_type arr_wr_ff, nxt_arr_wr, arr_rd_ff, nxt_arr_rd;
    logic [DQ_W-1:0] wdata_ff, nxt_wdata;
    logic [MASK_W-1:0] wbe_ff, nxt_wbe;
    logic [BANK_W-1:0] sel_bank;
    logic bst_start, bst_single, bst_term, bst_busy, bst_last;
    logic [COL_W-1:0] bst_col;
    logic beat_go, beat_done;
    logic [COL_W-1:0] beat_col;

    assign sel_bank = {bank_select_high, bank_select};

    // Only self-refresh entry passes with the enable low.
    always_comb begin
        cmd = scd_decode(cmd_pins);
        if (!ctrl_ff[0] || pwr_ff != PWR_ACTIVE) begin
            cmd = CMD_INHIBIT;
        end
        if (!clock_enable_input && cmd != CMD_REFRESH) begin
            cmd = CMD_INHIBIT;
        end
    end

    // Beat selection: a new read or write wins over a running burst.
    always_comb begin
        bst_start = clock_enable_input && (cmd == CMD_READ || cmd == CMD_WRITE);
        bst_single = (cmd == CMD_WRITE) && mode_ff[WBM_BIT];
        bst_term = cmd == CMD_TERMINATE;
        beat_go = 1'b0;
        beat_done = 1'b0;
        beat_col = bst_col;
        if (bst_start) begin
            beat_go = 1'b1;
            beat_col = address[COL_W-1:0];
            beat_done = bst_single || mode_ff[BL_LSB+:3] == BL_1;
        end else if (clock_enable_input && bst_busy && !bst_term) begin
            beat_go = 1'b1;
            beat_done = bst_last;
        end
    end

    scd_burst #(
        .COL_W(COL_W)
    ) u_burst (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(clock_enable_input),
        .start(bst_start),
        .single(bst_single),
        .terminate(bst_term),
        .len_code(mode_ff[BL_LSB+:3]),
        .start_col(address[COL_W-1:0]),
        .busy(bst_busy),
        .last(bst_last),
        .col(bst_col)
    );

    // Command execution; only self-refresh entry acts while the enable is low.
    always_comb begin
        nxt_pwr = pwr_ff;
        nxt_mode = mode_ff;
        nxt_open = open_ff;
        nxt_row = row_ff;
        nxt_refresh = refresh_ff;
        nxt_bwrite = bwrite_ff;
        nxt_bap = bap_ff;
        nxt_bbank = bbank_ff;
        nxt_arr_wr = '0;
        nxt_arr_rd = '0;
        nxt_wdata = wdata_ff;
        nxt_wbe = wbe_ff;
        if (pwr_ff == PWR_SELF_REFRESH) begin
            if (clock_enable_input) begin
                nxt_pwr = PWR_ACTIVE;
            end
        end else if (!clock_enable_input) begin
            if (cmd == CMD_REFRESH) begin
                nxt_pwr = PWR_SELF_REFRESH;
                nxt_refresh = refresh_ff + 1'b1;
            end
        end else begin
            case (cmd)
                CMD_ACTIVATE: begin
                    nxt_open[sel_bank] = 1'b1;
                    nxt_row[sel_bank] = address;
                end
                CMD_PRECHARGE: begin
                    if (address[AP_BIT]) begin
                        nxt_open = '0;
                    end else begin
                        nxt_open[sel_bank] = 1'b0;
                    end
                end
                CMD_REFRESH: begin
                    nxt_refresh = refresh_ff + 1'b1;
                end
                CMD_LOAD_MODE: begin
                    nxt_mode = address[MODE_W-1:0];
                end
                CMD_READ, CMD_WRITE: begin
                    nxt_bwrite = cmd == CMD_WRITE;
                    nxt_bbank = sel_bank;
                    nxt_bap = address[AP_BIT] && mode_ff[BL_LSB+:3] != BL_FULL;
                end
                CMD_TERMINATE: begin
                    if (bst_busy && bap_ff) begin
                        nxt_open[bbank_ff] = 1'b0;
                    end
                end
                default: begin
                end
            endcase
            if (beat_go) begin
                if (nxt_bwrite) begin
                    nxt_arr_wr = '{1'b1, nxt_bbank, row_ff[nxt_bbank], beat_col};
                    nxt_wdata = dq_in;
                    nxt_wbe = ~byte_mask;
                end else begin
                    nxt_arr_rd = '{1'b1, nxt_bbank, row_ff[nxt_bbank], beat_col};
                end
                if (beat_done && nxt_bap) begin
                    nxt_open[nxt_bbank] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_ff <= PWR_ACTIVE;
            mode_ff <= MODE_RESET;
            for (int i = 0; i < NBANK; i++) begin
                row_ff[i] <= '0;
            end
            {open_ff, refresh_ff, bwrite_ff, bap_ff, bbank_ff} <= '0;
            {arr_wr_ff, arr_rd_ff, wdata_ff, wbe_ff} <= '0;
        end else begin
            pwr_ff <= nxt_pwr;
            mode_ff <= nxt_mode;
            row_ff <= nxt_row;
            {open_ff, refresh_ff, bwrite_ff} <= {nxt_open, nxt_refresh, nxt_bwrite};
            {bap_ff, bbank_ff, arr_wr_ff} <= {nxt_bap, nxt_bbank, nxt_arr_wr};
            {arr_rd_ff, wdata_ff, wbe_ff} <= {nxt_arr_rd, nxt_wdata, nxt_wbe};
        end
    end

    assign {arr_wr, arr_rd} = {arr_wr_ff, arr_rd_ff};
    assign {arr_wr_data, arr_wr_be} = {wdata_ff, wbe_ff};

    // Read pipe: latency two takes the array answer straight, three adds a stage.
    logic stg_v_ff, nxt_stg_v, dqv_ff;
    logic [DQ_W-1:0] stg_d_ff, nxt_stg_d, dq_ff, nxt_dq;
    logic [MASK_W-1:0] mask_ff, nxt_mask, oe_ff, nxt_oe;
    logic nxt_dqv;

    always_comb begin
        nxt_stg_v = stg_v_ff;
        nxt_stg_d = stg_d_ff;
        nxt_mask = mask_ff;
        nxt_dq = dq_ff;
        nxt_dqv = dqv_ff;
        nxt_oe = oe_ff;
        if (clock_enable_input) begin
            nxt_stg_v = arr_rd_ff.en;
            nxt_stg_d = arr_rd_data;
            nxt_mask = byte_mask;
            if (mode_ff[CL_LSB+:3] == CL_2) begin
                nxt_dqv = arr_rd_ff.en;
                nxt_dq = arr_rd_data;
            end else begin
                nxt_dqv = stg_v_ff;
                nxt_dq = stg_d_ff;
            end
            nxt_oe = nxt_dqv ? ~mask_ff : '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {stg_v_ff, stg_d_ff, mask_ff, dq_ff, dqv_ff, oe_ff} <= '0;
        end else begin
            {stg_v_ff, stg_d_ff, mask_ff} <= {nxt_stg_v, nxt_stg_d, nxt_mask};
            {dq_ff, dqv_ff, oe_ff} <= {nxt_dq, nxt_dqv, nxt_oe};
        end
    end

    assign {dq_out, dq_oe} = {dq_ff, oe_ff};

    // Register slave; address and data latch apart, so either may lead.
    logic [31:0] rdata_ff, nxt_rdata, rd_word;
    logic aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have, bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic awready_ff, nxt_awready, wready_ff, nxt_wready, arready_ff, nxt_arready;
    logic [AXI_AW-1:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_reg_ff, nxt_wdata_reg;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic rd_hit;

    // Status shows open banks, burst activity, self refresh and a reserved mode.
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            REG_CTRL: rd_word = ctrl_ff;
            REG_MODE: rd_word = {20'h00000, mode_ff};
            REG_STATUS: rd_word = {25'h0000000, mode_ff[OPM_LSB+:2] != 2'h0,
                                   pwr_ff == PWR_SELF_REFRESH, bst_busy, open_ff};
            REG_REFRESH: rd_word = {19'h00000, refresh_ff};
            default: begin
                rd_word = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_aw_have = aw_have_ff;
        nxt_awaddr = awaddr_ff;
        nxt_w_have = w_have_ff;
        nxt_wdata_reg = wdata_reg_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_awvalid && awready_ff) begin
            nxt_aw_have = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_ff) begin
            nxt_w_have = 1'b1;
            nxt_wdata_reg = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end else if (aw_have_ff && w_have_ff && !bvalid_ff) begin
            nxt_aw_have = 1'b0;
            nxt_w_have = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            if (awaddr_ff == REG_CTRL) begin
                if (wstrb_ff[0]) begin
                    nxt_ctrl = {31'h00000000, wdata_reg_ff[0]};
                end
            end else if (awaddr_ff != REG_MODE && awaddr_ff != REG_STATUS && awaddr_ff != REG_REFRESH) begin
                nxt_bresp = RESP_SLVERR;
            end
        end
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (s_axi_arvalid && arready_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rdata = rd_word;
            nxt_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        nxt_awready = !nxt_aw_have;
        nxt_wready = !nxt_w_have;
        nxt_arready = !nxt_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= CTRL_RESET;
            {aw_have_ff, awaddr_ff, w_have_ff, wdata_reg_ff, wstrb_ff, bvalid_ff} <= '0;
            {rvalid_ff, rdata_ff, awready_ff, wready_ff, arready_ff} <= '0;
            bresp_ff <= RESP_OKAY;
            rresp_ff <= RESP_OKAY;
        end else begin
            ctrl_ff <= nxt_ctrl;
            {aw_have_ff, awaddr_ff, w_have_ff} <= {nxt_aw_have, nxt_awaddr, nxt_w_have};
            {wdata_reg_ff, wstrb_ff, bvalid_ff, bresp_ff} <= {nxt_wdata_reg, nxt_wstrb, nxt_bvalid, nxt_bresp};
            {rvalid_ff, rdata_ff, rresp_ff} <= {nxt_rvalid, nxt_rdata, nxt_rresp};
            {awready_ff, wready_ff, arready_ff} <= {nxt_awready, nxt_wready, nxt_arready};
        end
    end

    assign {s_axi_awready, s_axi_wready, s_axi_arready} = {awready_ff, wready_ff, arready_ff};
    assign {s_axi_bvalid, s_axi_bresp} = {bvalid_ff, bresp_ff};
    assign {s_axi_rvalid, s_axi_rdata, s_axi_rresp} = {rvalid_ff, rdata_ff, rresp_ff};
endmodule
`default_nettype wire

/* hdl/scd_pkg.sv */
// How it works
// - Mode bits 7 and 8 zero for normal.
// - Write-burst bit set makes writes single-location.
// - Chip select high ignores all strobes.
// - Selected with strobes high is a no-op.
// - Activate opens addressed row in chosen bank.
// - Read starts burst at column A0-9.
// - Address bit 10 arms auto precharge per command.
// - Read mask high floats bytes two cycles later.
// - Write starts burst at column A0-9.
// - Write mask applies to same-cycle data.
// - Precharge closes one bank, or all with bit 10.
// - Refresh is auto, or self with enable low.
// - Refresh rows come from internal counter.
// - Mode load stores address bits 0 to 11.
// - Burst terminate truncates the latest burst.
// - Read data driven after n+m-1, valid by n+m.
// - Mode fields: length, type, latency, mode, write-burst.
`default_nettype none
package scd_pkg;
    localparam int ROW_W = 13;
    localparam int COL_W = 10;
    localparam int BANK_W = 2;
    localparam int MODE_W = 12;
    localparam int AXI_AW = 8;
    localparam int AP_BIT = 10;
    localparam int BL_LSB = 0;
    localparam int CL_LSB = 4;
    localparam int OPM_LSB = 7;
    localparam int WBM_BIT = 9;
    localparam logic [MODE_W-1:0] MODE_RESET = 12'h020;
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] REG_MODE = 8'h04;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h08;
    localparam logic [AXI_AW-1:0] REG_REFRESH = 8'h0C;
    localparam logic [31:0] CTRL_RESET = 32'h00000001;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic chip_select_n;
        logic row_strobe_n;
        logic column_strobe_n;
        logic write_enable_n;
    } scd_cmd_pins_type;

    typedef struct packed {
        logic en;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
    } scd_arr_type;

    typedef enum logic [3:0] {
        CMD_INHIBIT, CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE,
        CMD_TERMINATE, CMD_PRECHARGE, CMD_REFRESH, CMD_LOAD_MODE
    } scd_cmd_type;

    typedef enum logic [0:0] {PWR_ACTIVE, PWR_SELF_REFRESH} scd_pwr_type;

    // Truth-table decode of the four command strobes.
    function automatic scd_cmd_type scd_decode(input scd_cmd_pins_type p);
        scd_cmd_type c;
        c = CMD_INHIBIT;
        if (!p.chip_select_n) begin
            case ({p.row_strobe_n, p.column_strobe_n, p.write_enable_n})
                3'h7: c = CMD_NOP;
                3'h3: c = CMD_ACTIVATE;
                3'h5: c = CMD_READ;
                3'h4: c = CMD_WRITE;
                3'h6: c = CMD_TERMINATE;
                3'h2: c = CMD_PRECHARGE;
                3'h1: c = CMD_REFRESH;
                default: c = CMD_LOAD_MODE;
            endcase
        end
        return c;
    endfunction

    // Beats per burst; reserved codes give one beat.
    function automatic logic [COL_W:0] scd_beats(input logic [2:0] code);
        logic [COL_W:0] n;
        case (code)
            BL_2: n = 11'h002;
            BL_4: n = 11'h004;
            BL_8: n = 11'h008;
            BL_FULL: n = 11'h400;
            default: n = 11'h001;
        endcase
        return n;
    endfunction
endpackage
`default_nettype wire

/* hdl/scd_burst.sv */
`timescale 1ns/10ps
`default_nettype none
module scd_burst #(
    parameter int COL_W = scd_pkg::COL_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic start,
    input wire logic single,
    input wire logic terminate,
    input wire logic [2:0] len_code,
    input wire logic [COL_W-1:0] start_col,
    output logic busy,
    output logic last,
    output logic [COL_W-1:0] col
);
    import scd_pkg::*;

    logic [COL_W:0] rem_ff, nxt_rem;
    logic [COL_W-1:0] col_ff, nxt_col, mask_ff, nxt_mask;
    logic full_ff, nxt_full;

    initial begin
        if (COL_W < 3 || COL_W > scd_pkg::COL_W) begin
            $error("scd_burst: COL_W out of range");
        end
    end

    // Columns step upward and wrap inside the burst block.
    function automatic logic [COL_W-1:0] wrap(input logic [COL_W-1:0] c, input logic [COL_W-1:0] m);
        return (c & ~m) | ((c + 1'b1) & m);
    endfunction

    assign busy = full_ff | (rem_ff != '0);
    assign last = !full_ff && (rem_ff == 1);
    assign col = col_ff;

    // Remaining beats after the one taken with the command itself.
    always_comb begin
        nxt_rem = rem_ff;
        nxt_col = col_ff;
        nxt_mask = mask_ff;
        nxt_full = full_ff;
        if (ce) begin
            if (start) begin
                nxt_mask = single ? '0 : COL_W'(scd_beats(len_code) - 1'b1);
                nxt_full = !single && len_code == BL_FULL;
                nxt_rem = single ? '0 : scd_beats(len_code) - 1'b1;
                nxt_col = wrap(start_col, nxt_mask);
            end else if (terminate) begin
                nxt_rem = '0;
                nxt_full = 1'b0;
            end else if (busy) begin
                nxt_col = wrap(col_ff, mask_ff);
                nxt_rem = full_ff ? rem_ff : rem_ff - 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {rem_ff, col_ff, mask_ff, full_ff} <= '0;
        end else begin
            {rem_ff, col_ff, mask_ff, full_ff} <= {nxt_rem, nxt_col, nxt_mask, nxt_full};
        end
    end
endmodule
`default_nettype wire

/* dv/scd_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module scd_monitor #(
    parameter int DQ_W = 64,
    parameter int MASK_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clock_enable_input,
    input wire scd_pkg::scd_cmd_pins_type cmd_pins,
    input wire logic [scd_pkg::ROW_W-1:0] address,
    input wire logic bank_select,
    input wire logic bank_select_high,
    input wire logic [MASK_W-1:0] byte_mask,
    input wire logic [DQ_W-1:0] dq_in,
    input wire logic [DQ_W-1:0] dq_out,
    input wire logic [MASK_W-1:0] dq_oe,
    input wire scd_pkg::scd_arr_type arr_wr,
    input wire logic [DQ_W-1:0] arr_wr_data,
    input wire logic [MASK_W-1:0] arr_wr_be,
    input wire scd_pkg::scd_arr_type arr_rd,
    input wire logic [DQ_W-1:0] arr_rd_data
);
    import scd_pkg::*;
    logic [3:0] pins;
    logic [MODE_W-1:0] mode_ff, nxt_mode;
    logic [ROW_W-1:0] row_ff [4], nxt_row [4];
    logic [ROW_W-1:0] cur_row;
    logic wr, rd, rw, cl2, idle, wr4;
    // Command views; quiet means nop or deselect, enabled.
    assign pins = cmd_pins;
    assign wr = clock_enable_input && pins == 4'h4;
    assign rd = clock_enable_input && pins == 4'h5;
    assign rw = wr || rd;
    assign idle = clock_enable_input && (pins == 4'h7 || pins[3]);
    assign cl2 = mode_ff[6:4] == CL_2;
    assign wr4 = wr && !mode_ff[WBM_BIT] && mode_ff[2:0] == BL_4;
    assign cur_row = row_ff[{bank_select_high, bank_select}];
    // Shadow mode register and rows; modes load only with the clock enable high.
    always_comb begin
        nxt_mode = mode_ff;
        nxt_row = row_ff;
        if (clock_enable_input && pins == 4'h0) begin
            nxt_mode = address[MODE_W-1:0];
        end
        if (clock_enable_input && pins == 4'h3) begin
            nxt_row[{bank_select_high, bank_select}] = address;
        end
    end
    always_ff @(posedge aclk) begin
        mode_ff <= aresetn ? nxt_mode : MODE_RESET;
        row_ff <= nxt_row;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    write_beat_a: assert property (
        wr |=> arr_wr.en && arr_wr.col == $past(address[9:0]) && arr_wr_be == ~$past(byte_mask)
        && arr_wr_data == $past(dq_in)) else $error("write beat wrong");
    read_row_a: assert property (
        rd |=> arr_rd.en && arr_rd.col == $past(address[9:0]) && arr_rd.row == $past(cur_row))
        else $error("read beat wrong");
    read_lat2_a: assert property (
        rd && cl2 |=> ##1 dq_oe == ~$past(byte_mask, 2) && ($past(byte_mask, 2) != 0
        || dq_out == $past(arr_rd_data))) else $error("latency two data wrong");
    read_lat3_a: assert property (
        rd && !cl2 |=> ##2 dq_oe == ~$past(byte_mask, 2)) else $error("latency three mask wrong");
    quiet_cycle_a: assert property (
        clock_enable_input && !rw && mode_ff[2:0] == BL_1 |=> !arr_wr.en && !arr_rd.en)
        else $error("strobe without access");
    frozen_core_a: assert property (
        !clock_enable_input |=> !arr_wr.en && !arr_rd.en) else $error("strobe while disabled");
    write_single_a: assert property (
        wr && mode_ff[WBM_BIT] ##1 !rw |=> !arr_wr.en) else $error("write not single");
    burst_wrap_a: assert property (
        wr4 ##1 idle [*3] |=> arr_wr.en && arr_wr.col[1:0] == $past(address[1:0], 4) + 2'h3)
        else $error("burst order wrong");
    burst_stop_a: assert property (
        wr4 ##1 (clock_enable_input && pins == 4'h6) ##1 idle |=> !arr_wr.en) else $error("not truncated");
    cover property (rd && !cl2);
    cover property (wr && mode_ff[WBM_BIT]);
    cover property (wr4 ##1 idle [*3]);
endmodule
bind scd_top scd_monitor #(.DQ_W(DQ_W), .MASK_W(MASK_W)) u_mon (.aclk(aclk), .aresetn(aresetn),
    .clock_enable_input(clock_enable_input), .cmd_pins(cmd_pins), .address(address),
    .bank_select(bank_select), .bank_select_high(bank_select_high), .byte_mask(byte_mask),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .arr_wr(arr_wr), .arr_wr_data(arr_wr_data),
    .arr_wr_be(arr_wr_be), .arr_rd(arr_rd), .arr_rd_data(arr_rd_data));
`default_nettype wire

/* dv/scd_array_model.sv */
`timescale 1ns/10ps
`default_nettype none
module scd_array_model (
    input wire scd_pkg::scd_arr_type arr_rd,
    output logic [63:0] arr_rd_data
);
    // Data names its own bank, row and column, so a wrong address shows; idle bus is inverted.
    always_comb begin
        arr_rd_data = {8'hC3, 6'h00, arr_rd.bank, 3'h0, arr_rd.row, 22'h000000, arr_rd.col};
        if (!arr_rd.en) begin
            arr_rd_data = ~arr_rd_data;
        end
    end
endmodule
`default_nettype wire

/* dv/sdram_command_decoder_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module sdram_command_decoder_bench;
    import scd_pkg::*;
    logic aclk, aresetn, ce, bs, bsh, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [3:0] pins;
    logic [12:0] addr;
    logic [7:0] mask, awaddr, araddr, dq_oe;
    logic [63:0] dq_in, dq_out, rdd;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    scd_arr_type ard;
    int error_cnt = 0;
    int checks = 0;
    scd_top dut (.aclk(aclk), .aresetn(aresetn), .clock_enable_input(ce), .cmd_pins(scd_cmd_pins_type'(pins)),
        .address(addr), .bank_select(bs), .bank_select_high(bsh), .byte_mask(mask), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .arr_wr(), .arr_wr_data(), .arr_wr_be(), .arr_rd(ard),
        .arr_rd_data(rdd), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp));
    scd_array_model u_arr (.arr_rd(ard), .arr_rd_data(rdd));
    // Free-running 200 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic stop_test();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Idle cycles carry a nop with every byte masked.
    task automatic nap(input int n);
        pins <= 4'h7;
        mask <= 8'hFF;
        repeat (n) @(posedge aclk);
    endtask
    // One command for one edge; the next call or wait replaces it.
    task automatic mc(input logic [3:0] p, input logic [12:0] a, input logic [1:0] b, input logic [7:0] m);
        pins <= p;
        addr <= a;
        {bsh, bs} <= b;
        mask <= m;
        @(posedge aclk);
    endtask
    // Address and data go out together; each drops when taken. Response readies stay high.
    task automatic aw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int i = 0;
        pins <= 4'h7;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            i++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && i < 50);
        if (i >= 50) begin
            error_cnt++;
            stop_test();
        end
        chk("bresp", r, bresp);
    endtask
    task automatic ar(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        int i = 0;
        pins <= 4'h7;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            i++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && i < 50);
        if (i >= 50) begin
            error_cnt++;
            stop_test();
        end
        chk("rresp", r, rresp);
        if (r == RESP_OKAY) chk("rdata", e, rdata);
    endtask
    // Main sequence; waits after precharge and mode load are the controller's duty.
    initial begin
        {aresetn, bs, bsh, awvalid, wvalid, arvalid} = '0;
        {ce, bready, rready, pins, addr, mask, dq_in, awaddr, araddr, wdata} = {3'h7, 4'h7, 13'h0, 8'hFF, 64'h0, 48'h0};
        nap(3);
        aresetn <= 1'b1;
        @(posedge aclk);
        ar(REG_MODE, 32'h020, RESP_OKAY);
        ar(REG_CTRL, 32'h1, RESP_OKAY);
        aw(REG_CTRL, 32'h0, RESP_OKAY);
        ar(REG_CTRL, 32'h0, RESP_OKAY);
        aw(REG_CTRL, 32'h1, RESP_OKAY);
        aw(REG_MODE, 32'h3FF, RESP_OKAY);
        ar(REG_MODE, 32'h020, RESP_OKAY);
        aw(8'h10, 32'h0, RESP_SLVERR);
        ar(8'h10, 32'h0, RESP_SLVERR);
        mc(4'h3, 13'h1ABC, 2'h1, 8'hFF);
        mc(4'h5, 13'h0005, 2'h1, 8'h0F);
        nap(2);
        chk("dq_oe", 8'hF0, dq_oe);
        chk("dq_out", {8'hC3, 8'h01, 16'h1ABC, 32'h0}, dq_out & 64'hFFFFFFFF_00000000);
        ar(REG_STATUS, 32'h02, RESP_OKAY);
        mc(4'hC, 13'h0000, 2'h0, 8'h00);
        mc(4'h3, 13'h0007, 2'h0, 8'hFF);
        mc(4'h2, 13'h0000, 2'h1, 8'hFF);
        ar(REG_STATUS, 32'h01, RESP_OKAY);
        mc(4'h2, 13'h0400, 2'h1, 8'hFF);
        nap(2);
        ar(REG_STATUS, 32'h00, RESP_OKAY);
        mc(4'h0, 13'h0032, 2'h0, 8'hFF);
        nap(2);
        ar(REG_MODE, 32'h032, RESP_OKAY);
        mc(4'h3, 13'h0005, 2'h2, 8'hFF);
        dq_in <= 64'h0123456789ABCDEF;
        mc(4'h4, 13'h0406, 2'h2, 8'h81);
        nap(6);
        ar(REG_STATUS, 32'h00, RESP_OKAY);
        mc(4'h3, 13'h0005, 2'h2, 8'hFF);
        mc(4'h5, 13'h0002, 2'h2, 8'h00);
        nap(5);
        mc(4'h4, 13'h0001, 2'h2, 8'h00);
        mc(4'h6, 13'h0000, 2'h0, 8'hFF);
        nap(4);
        ar(REG_STATUS, 32'h04, RESP_OKAY);
        mc(4'h2, 13'h0400, 2'h0, 8'hFF);
        nap(2);
        mc(4'h0, 13'h0232, 2'h0, 8'hFF);
        nap(2);
        mc(4'h3, 13'h0009, 2'h3, 8'hFF);
        mc(4'h4, 13'h0400, 2'h3, 8'h00);
        nap(6);
        ar(REG_STATUS, 32'h00, RESP_OKAY);
        mc(4'h0, 13'h01A0, 2'h0, 8'hFF);
        nap(2);
        ar(REG_STATUS, 32'h40, RESP_OKAY);
        mc(4'h0, 13'h0020, 2'h0, 8'hFF);
        nap(2);
        mc(4'h1, 13'h1FFF, 2'h3, 8'h00);
        ar(REG_REFRESH, 32'h1, RESP_OKAY);
        ce <= 1'b0;
        mc(4'h1, 13'h0000, 2'h0, 8'hFF);
        nap(3);
        ar(REG_STATUS, 32'h20, RESP_OKAY);
        ar(REG_REFRESH, 32'h2, RESP_OKAY);
        ce <= 1'b1;
        nap(3);
        ar(REG_STATUS, 32'h00, RESP_OKAY);
        stop_test();
    end
endmodule
`default_nettype wire
